/* core/ddr2c_regs.vh */
/*
 * Constants of the command, initialisation and mode logic: address
 * field positions, command and mode codes, and the layout of the
 * write-data word handed out by the core.
 * Assumes plain Verilog-2005 and inclusion by its bare name.
 */
`ifndef DDR2C_REGS_VH
`define DDR2C_REGS_VH

// pins carried through the synchroniser as one vector
`define DDR2C_PIN_W 41
// main_operating_mode layout (address bits at the mode write)
`define DDR2C_MODE_W 14
`define DDR2C_MODE_RST 14'h0000
`define DDR2C_BL_MSB 2
`define DDR2C_BL_LSB 0
`define DDR2C_BT_BIT 3
`define DDR2C_CL_MSB 6
`define DDR2C_CL_LSB 4
`define DDR2C_TM_BIT 7
`define DDR2C_DLLRST_BIT 8
`define DDR2C_WR_MSB 11
`define DDR2C_WR_LSB 9
`define DDR2C_BL_FOUR 3'h2
`define DDR2C_BL_EIGHT 3'h3
// extended_operating_mode fields
`define DDR2C_DLL_BIT 0
`define DDR2C_CAL_MSB 9
`define DDR2C_CAL_LSB 7
`define DDR2C_CAL_EXIT 3'h0
`define DDR2C_CAL_DRIVE1 3'h1
`define DDR2C_CAL_DRIVE0 3'h2
`define DDR2C_CAL_ADJUST 3'h4
`define DDR2C_CAL_DEFAULT 3'h7
// register select on BA1:BA0
`define DDR2C_SEL_MAIN 2'h0
`define DDR2C_SEL_EXT1 2'h1
`define DDR2C_SEL_EXT2 2'h2
`define DDR2C_SEL_EXT3 2'h3
// address bits of commands
`define DDR2C_AP_BIT 10
`define DDR2C_COL_W 10
`define DDR2C_ROW_W 14
// RAS#, CAS#, WE# command codes
`define DDR2C_C_ACT 3'h3
`define DDR2C_C_PRE 3'h2
`define DDR2C_C_RD 3'h5
`define DDR2C_C_WR 3'h4
`define DDR2C_C_MRS 3'h0
`define DDR2C_C_REF 3'h1
`define DDR2C_C_NOP 3'h7
// burst beats and latency corner
`define DDR2C_BEATS4 3'h3
`define DDR2C_BEATS8 3'h7
`define DDR2C_ONE3 3'h1
`define DDR2C_BANKS_NONE 8'h00
`define DDR2C_BANKS_ALL 8'hff
// write word: {bank, column, byte enables, data}
`define DDR2C_WW 31
`define DDR2C_BUF_DEPTH 2

`endif

/* core/ddr2c_sync.v */
/*
 * Two-flop synchroniser for a vector of pin levels.
 * Assumes each bit is a level slow enough against clk_sys_in that
 * bits of one vector may be read together after two stages.
 */
`timescale 1ns/10ps
`default_nettype none
module ddr2c_sync #(
	parameter W = 1
) (
	input wire clk_sys_in,
	input wire resetn_in,
	input wire [W-1:0] d_in,
	output reg [W-1:0] q_out
);

reg [W-1:0] meta;

// first stage feeds only the second
always @(posedge clk_sys_in or negedge resetn_in) begin
	if (!resetn_in) begin
		meta <= {W{1'b0}};
		q_out <= {W{1'b0}};
	end else begin
		meta <= d_in;
		q_out <= meta;
	end
end

endmodule // ddr2c_sync
`default_nettype wire

/* core/ddr2c_buf.v */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock; the drain side may hold ready low at will.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ddr2c_regs.vh"
module ddr2c_buf (
	input wire clk_sys_in,
	input wire resetn_in,
	input wire in_valid_in,
	input wire [`DDR2C_WW-1:0] in_data_in,
	output wire in_ready_out,
	output wire out_valid_out,
	output wire [`DDR2C_WW-1:0] out_data_out,
	input wire out_ready_in
);

reg [`DDR2C_WW-1:0] mem [0:`DDR2C_BUF_DEPTH-1];
reg wr_ptr;
reg rd_ptr;
reg [1:0] count;
wire push;
wire pop;

assign in_ready_out = (count != 2'h2);
assign out_valid_out = (count != 2'h0);
assign out_data_out = mem[rd_ptr];
assign push = in_valid_in & in_ready_out;
assign pop = out_valid_out & out_ready_in;

// storage has no reset; valid gates it
always @(posedge clk_sys_in) begin
	if (push) begin
		mem[wr_ptr] <= in_data_in;
	end
end

// pointers and occupancy
always @(posedge clk_sys_in or negedge resetn_in) begin
	if (!resetn_in) begin
		wr_ptr <= 1'b0;
		rd_ptr <= 1'b0;
		count <= 2'h0;
	end else begin
		if (push) begin
			wr_ptr <= ~wr_ptr;
		end
		if (pop) begin
			rd_ptr <= ~rd_ptr;
		end
		if (push & ~pop) begin
			count <= count + 2'h1;
		end else if (pop & ~push) begin
			count <= count - 2'h1;
		end
	end
end

endmodule // ddr2c_buf
`default_nettype wire

/* core/ddr2c_cmd.v */
/*
 * Command decode, power state, bank tracking, mode register capture
 * and masked write-data capture of a DDR2 memory die, run on clk_sys_in.
 * Assumes the memory clock pin is far slower than clk_sys_in (sampled
 * and edge-detected here) and that the controller keeps the
 * initialisation order and mode-set spacing on its own.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ddr2c_regs.vh"
module ddr2c_cmd (
	input wire clk_sys_in,
	input wire resetn_in,
	input wire ck_in,
	input wire cke_in,
	input wire cs_n_in,
	input wire ras_n_in,
	input wire cas_n_in,
	input wire we_n_in,
	input wire [2:0] ba_in,
	input wire [13:0] addr_in,
	input wire lower_byte_mask_in,
	input wire upper_byte_mask_in,
	input wire [15:0] dq_in,
	input wire wdata_ready_in,
	output wire wdata_valid_out,
	output wire [`DDR2C_WW-1:0] wdata_out,
	output wire wdata_accept_out,
	output reg cmd_activate_out,
	output reg cmd_read_out,
	output reg cmd_write_out,
	output reg cmd_precharge_out,
	output reg cmd_refresh_out,
	output reg cmd_mode_out,
	output reg cmd_error_out,
	output reg [2:0] cmd_bank_out,
	output reg [13:0] cmd_row_out,
	output reg [9:0] cmd_col_out,
	output reg cmd_auto_pre_out,
	output reg cmd_all_banks_out,
	output reg [1:0] cmd_mode_sel_out,
	output reg [7:0] bank_open_out,
	output reg [2:0] power_state_out,
	output reg mode_valid_out,
	output reg [`DDR2C_MODE_W-1:0] main_operating_mode,
	output reg [`DDR2C_MODE_W-1:0] extended_operating_mode,
	output wire burst_eight_out,
	output wire burst_interleave_out,
	output wire [2:0] cas_latency_out,
	output wire [2:0] cal_op_out
);

// power states, one-hot
localparam P_NORM = 3'b001;
localparam P_PDN = 3'b010;
localparam P_SREF = 3'b100;
// write burst states, one-hot
localparam W_IDLE = 3'b001;
localparam W_WAIT = 3'b010;
localparam W_DATA = 3'b100;

// burst column for beat i: sequential wraps, interleaved xors
function [9:0] burst_col;
	input [9:0] start;
	input [2:0] i;
	input eight;
	input ilv;
	reg [2:0] low;
	begin
		low = ilv ? (start[2:0] ^ i) : (start[2:0] + i);
		if (eight) begin
			burst_col = {start[9:3], low};
		end else begin
			burst_col = {start[9:2], low[1:0]};
		end
	end
endfunction

// one-hot bank mask
function [7:0] bank_bit;
	input [2:0] b;
	begin
		bank_bit = 8'h01 << b;
	end
endfunction

wire [`DDR2C_PIN_W-1:0] pins_s;
wire ck_s;
wire cke_s;
wire cs_n_s;
wire [2:0] code_s;
wire [2:0] ba_s;
wire [13:0] a_s;
wire ldm_s;
wire udm_s;
wire [15:0] dq_s;
reg ck_d;
reg cke_prev;
wire rise;
wire fall;
wire take;
wire is_nop;
wire is_ref;
wire col_ok;
wire [2:0] beats;
wire [1:0] be;
wire push;
wire buf_ready;
wire [7:0] wclose;
reg [2:0] pstate;
reg [2:0] wstate;
reg [2:0] wcnt;
reg [2:0] beat;
reg [2:0] wbank;
reg [9:0] wcol;
reg wauto;

// every pin crosses into clk_sys_in through two flops
ddr2c_sync #(
	.W(`DDR2C_PIN_W)
) u_sync (
	.clk_sys_in(clk_sys_in),
	.resetn_in(resetn_in),
	.d_in({ck_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
		ba_in, addr_in, lower_byte_mask_in, upper_byte_mask_in, dq_in}),
	.q_out(pins_s)
);

assign ck_s = pins_s[40];
assign cke_s = pins_s[39];
assign cs_n_s = pins_s[38];
assign code_s = pins_s[37:35];
assign ba_s = pins_s[34:32];
assign a_s = pins_s[31:18];
assign ldm_s = pins_s[17];
assign udm_s = pins_s[16];
assign dq_s = pins_s[15:0];

// memory clock edges seen on the system clock
assign rise = ck_s & ~ck_d;
assign fall = ~ck_s & ck_d;

// commands count only with CKE high now and one clock earlier
assign take = rise & cke_prev & cke_s & ~cs_n_s;
assign is_nop = cs_n_s | (code_s == `DDR2C_C_NOP);
assign is_ref = ~cs_n_s & (code_s == `DDR2C_C_REF);

// main and extended register fields
assign burst_eight_out =
	(main_operating_mode[`DDR2C_BL_MSB:`DDR2C_BL_LSB] == `DDR2C_BL_EIGHT);
assign burst_interleave_out = main_operating_mode[`DDR2C_BT_BIT];
assign cas_latency_out = main_operating_mode[`DDR2C_CL_MSB:`DDR2C_CL_LSB];
assign cal_op_out = extended_operating_mode[`DDR2C_CAL_MSB:`DDR2C_CAL_LSB];
assign beats = burst_eight_out ? `DDR2C_BEATS8 : `DDR2C_BEATS4;

// a column access to an idle bank is refused
assign col_ok = bank_open_out[ba_s];

// bank closed by a write auto precharge at its last beat
assign wclose = (wstate == W_DATA && (rise || fall) && beat == beats && wauto) ?
	bank_bit(wbank) : `DDR2C_BANKS_NONE;

// a byte whose mask is high is dropped; all-masked beats push nothing
assign be = {~udm_s, ~ldm_s};
assign push = (wstate == W_DATA || (wstate == W_WAIT && rise && wcnt == `DDR2C_ONE3))
	&& (rise || fall) && (be != 2'h0);

// clock edge and CKE history
always @(posedge clk_sys_in or negedge resetn_in) begin
	if (!resetn_in) begin
		ck_d <= 1'b0;
		cke_prev <= 1'b0;
	end else begin
		ck_d <= ck_s;
		if (rise) begin
			cke_prev <= cke_s;
		end
	end
end

// power-down and self refresh follow the CKE transition
always @(posedge clk_sys_in or negedge resetn_in) begin
	if (!resetn_in) begin
		pstate <= P_NORM;
	end else if (rise) begin
		case (pstate)
		P_NORM: begin
			if (cke_prev & ~cke_s & is_ref) begin
				pstate <= P_SREF;
			end else if (cke_prev & ~cke_s & is_nop) begin
				pstate <= P_PDN;
			end
		end
		P_PDN, P_SREF: begin
			if (~cke_prev & cke_s & is_nop) begin
				pstate <= P_NORM;
			end
		end
		default: begin
			pstate <= P_NORM;
		end
		endcase
	end
end

always @* begin
	power_state_out = pstate;
end

// command decode, bank tracking and mode capture
always @(posedge clk_sys_in or negedge resetn_in) begin
	if (!resetn_in) begin
		cmd_activate_out <= 1'b0;
		cmd_read_out <= 1'b0;
		cmd_write_out <= 1'b0;
		cmd_precharge_out <= 1'b0;
		cmd_refresh_out <= 1'b0;
		cmd_mode_out <= 1'b0;
		cmd_error_out <= 1'b0;
		cmd_bank_out <= 3'h0;
		cmd_row_out <= 14'h0000;
		cmd_col_out <= 10'h000;
		cmd_auto_pre_out <= 1'b0;
		cmd_all_banks_out <= 1'b0;
		cmd_mode_sel_out <= 2'h0;
		bank_open_out <= `DDR2C_BANKS_NONE;
		mode_valid_out <= 1'b0;
		main_operating_mode <= `DDR2C_MODE_RST;
		extended_operating_mode <= `DDR2C_MODE_RST;
	end else begin
		cmd_activate_out <= 1'b0;
		cmd_read_out <= 1'b0;
		cmd_write_out <= 1'b0;
		cmd_precharge_out <= 1'b0;
		cmd_refresh_out <= 1'b0;
		cmd_mode_out <= 1'b0;
		cmd_error_out <= 1'b0;
		// write auto precharge closes the bank at burst end; a command taken
		// in the same cycle starts from the closed image so neither is lost
		bank_open_out <= bank_open_out & ~wclose;
		if (take) begin
			cmd_bank_out <= ba_s;
			case (code_s)
			`DDR2C_C_ACT: begin
				cmd_activate_out <= 1'b1;
				cmd_row_out <= a_s;
				bank_open_out <= (bank_open_out & ~wclose) | bank_bit(ba_s);
			end
			`DDR2C_C_PRE: begin
				cmd_precharge_out <= 1'b1;
				cmd_all_banks_out <= a_s[`DDR2C_AP_BIT];
				if (a_s[`DDR2C_AP_BIT]) begin
					bank_open_out <= `DDR2C_BANKS_NONE;
				end else begin
					bank_open_out <= bank_open_out & ~wclose & ~bank_bit(ba_s);
				end
			end
			`DDR2C_C_RD: begin
				cmd_col_out <= a_s[`DDR2C_COL_W-1:0];
				cmd_auto_pre_out <= a_s[`DDR2C_AP_BIT];
				cmd_read_out <= col_ok;
				cmd_error_out <= ~col_ok;
				// reads carry no data here, so the bank closes at once
				if (col_ok & a_s[`DDR2C_AP_BIT]) begin
					bank_open_out <= bank_open_out & ~wclose & ~bank_bit(ba_s);
				end
			end
			`DDR2C_C_WR: begin
				cmd_col_out <= a_s[`DDR2C_COL_W-1:0];
				cmd_auto_pre_out <= a_s[`DDR2C_AP_BIT];
				cmd_write_out <= col_ok & (wstate == W_IDLE);
				cmd_error_out <= ~col_ok | (wstate != W_IDLE);
			end
			`DDR2C_C_MRS: begin
				cmd_mode_out <= 1'b1;
				cmd_mode_sel_out <= ba_s[1:0];
				if (ba_s[1:0] == `DDR2C_SEL_MAIN) begin
					main_operating_mode <= a_s;
					mode_valid_out <= 1'b1;
				end else if (ba_s[1:0] == `DDR2C_SEL_EXT1) begin
					extended_operating_mode <= a_s;
				end
			end
			`DDR2C_C_REF: begin
				cmd_refresh_out <= 1'b1;
			end
			default: begin
				cmd_bank_out <= cmd_bank_out;
			end
			endcase
		end
	end
end

// write burst: wait latency minus one clocks, then one beat per edge
always @(posedge clk_sys_in or negedge resetn_in) begin
	if (!resetn_in) begin
		wstate <= W_IDLE;
		wcnt <= 3'h0;
		beat <= 3'h0;
		wbank <= 3'h0;
		wcol <= 10'h000;
		wauto <= 1'b0;
	end else begin
		case (wstate)
		W_IDLE: begin
			if (take && code_s == `DDR2C_C_WR && col_ok) begin
				wbank <= ba_s;
				wcol <= a_s[`DDR2C_COL_W-1:0];
				wauto <= a_s[`DDR2C_AP_BIT];
				beat <= 3'h0;
				// latency of one or less is reserved; treat as two
				if (cas_latency_out > `DDR2C_ONE3) begin
					wcnt <= cas_latency_out - `DDR2C_ONE3;
				end else begin
					wcnt <= `DDR2C_ONE3;
				end
				wstate <= W_WAIT;
			end
		end
		W_WAIT: begin
			if (rise) begin
				if (wcnt == `DDR2C_ONE3) begin
					beat <= 3'h1;
					wstate <= W_DATA;
				end else begin
					wcnt <= wcnt - `DDR2C_ONE3;
				end
			end
		end
		W_DATA: begin
			if (rise || fall) begin
				if (beat == beats) begin
					wstate <= W_IDLE;
				end else begin
					beat <= beat + 3'h1;
				end
			end
		end
		default: begin
			wstate <= W_IDLE;
		end
		endcase
	end
end

// a beat offered while the buffer is full is lost; accept shows it
ddr2c_buf u_buf (
	.clk_sys_in(clk_sys_in),
	.resetn_in(resetn_in),
	.in_valid_in(push),
	.in_data_in({wbank, burst_col(wcol, beat, burst_eight_out,
		burst_interleave_out), be, dq_s}),
	.in_ready_out(buf_ready),
	.out_valid_out(wdata_valid_out),
	.out_data_out(wdata_out),
	.out_ready_in(wdata_ready_in)
);

assign wdata_accept_out = buf_ready;

endmodule // ddr2c_cmd
`default_nettype wire

/* sim/ddr2c_cmd_properties.sv */
/*
 * Concurrent checks on the outputs of the command core.
 * Assumes a bind onto ddr2c_cmd and the single clk_sys_in domain.
 */
`timescale 1ns/10ps
`default_nettype none
module ddr2c_cmd_properties (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic wdata_valid_out,
	input wire logic wdata_accept_out,
	input wire logic cmd_activate_out,
	input wire logic cmd_read_out,
	input wire logic cmd_write_out,
	input wire logic cmd_precharge_out,
	input wire logic cmd_mode_out,
	input wire logic cmd_error_out,
	input wire logic [2:0] cmd_bank_out,
	input wire logic cmd_all_banks_out,
	input wire logic [1:0] cmd_mode_sel_out,
	input wire logic [7:0] bank_open_out,
	input wire logic [2:0] power_state_out,
	input wire logic mode_valid_out,
	input wire logic [13:0] main_operating_mode,
	input wire logic [13:0] extended_operating_mode,
	input wire logic burst_eight_out,
	input wire logic burst_interleave_out,
	input wire logic [2:0] cas_latency_out,
	input wire logic [2:0] cal_op_out
);
	logic [7:0] prev_open;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// bank image one cycle back, the state a command was decoded against
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prev_open <= 8'h00;
		end else begin
			prev_open <= bank_open_out;
		end
	end
	sequence s_main_write;
		cmd_mode_out && cmd_mode_sel_out == 2'h0;
	endsequence
	a_power_onehot: assert property ($onehot(power_state_out))
		else $error("power state not one-hot");
	a_pulse_excl: assert property ($onehot0({cmd_activate_out, cmd_read_out,
		cmd_write_out, cmd_precharge_out, cmd_mode_out, cmd_error_out}))
		else $error("two command pulses at once");
	a_write_single: assert property (cmd_write_out |=> !cmd_write_out)
		else $error("write pulse longer than one cycle");
	a_act_opens: assert property (cmd_activate_out |-> ##[0:1] bank_open_out[cmd_bank_out])
		else $error("activated bank not open");
	a_read_open: assert property (cmd_read_out |-> prev_open[cmd_bank_out])
		else $error("read accepted on a closed bank");
	a_prech_all: assert property (cmd_precharge_out && cmd_all_banks_out
		|-> ##[0:1] bank_open_out == 8'h00) else $error("banks left open after precharge all");
	a_mode_latch: assert property (s_main_write |-> ##[0:1] mode_valid_out)
		else $error("main mode write not flagged");
	a_burst_len: assert property (mode_valid_out
		|-> burst_eight_out == (main_operating_mode[2:0] == 3'h3)) else $error("burst length decode");
	a_order_lat: assert property (burst_interleave_out == main_operating_mode[3]
		&& cas_latency_out == main_operating_mode[6:4]) else $error("order or latency decode");
	a_cal_field: assert property (cal_op_out == extended_operating_mode[9:7])
		else $error("calibration field decode");
	a_full_valid: assert property (!wdata_accept_out |-> wdata_valid_out)
		else $error("buffer refuses while empty");
endmodule // ddr2c_cmd_properties
`default_nettype wire

/* sim/ddr2c_ctl_model.sv */
/*
 * Memory controller model: free-running memory clock, command and write-data pins.
 * Assumes the bench calls its tasks from one process.
 */
`timescale 1ns/10ps
`default_nettype none
module ddr2c_ctl_model (
	input wire logic clk_sys_in,
	output logic ck_out,
	output logic cke_out,
	output logic cs_n_out,
	output logic ras_n_out,
	output logic cas_n_out,
	output logic we_n_out,
	output logic [2:0] ba_out,
	output logic [13:0] addr_out,
	output logic lower_byte_mask_out,
	output logic upper_byte_mask_out,
	output logic [15:0] dq_out
);
	// cke low and deselected from power-up; memory clock runs free
	initial begin
		{cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out} = 5'h0f;
		{ba_out, addr_out, upper_byte_mask_out, lower_byte_mask_out, dq_out} = '0;
		ck_out = 1'b0;
		#7.3;
		forever #40 ck_out = ~ck_out;
	end
	// one command at a ck rise, pins set mid-phase so the core sees them settled
	task automatic issue(input logic k, input logic cs, input logic [2:0] c,
		input logic [2:0] b, input logic [13:0] a);
		@(negedge ck_out);
		@(negedge clk_sys_in);
		{cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out, ba_out, addr_out} = {k, cs, c, b, a};
		@(posedge ck_out);
		repeat (5) @(negedge clk_sys_in);
		cs_n_out = 1'b1;
		{ba_out, addr_out} = ~{b, a}; // stale lines show garbage, not last value
	endtask
	// write beats on both ck edges, starting at rise number first
	task automatic burst(input int first, input int n, input logic [17:0] bt [8]);
		repeat (2 * first - 1) @(ck_out);
		repeat (5) @(negedge clk_sys_in);
		for (int i = 0; i < n; i++) begin
			{upper_byte_mask_out, lower_byte_mask_out, dq_out} = bt[i];
			@(ck_out);
			repeat (5) @(negedge clk_sys_in);
		end
		{upper_byte_mask_out, lower_byte_mask_out, dq_out} = ~bt[n - 1];
	endtask
endmodule // ddr2c_ctl_model
`default_nettype wire

/* sim/ddr2_command_init_mode_logic_tb.sv */
/*
 * Self-checking bench of the command core: init sequence, decode, modes, bursts, power.
 * Assumes the core, its header, the controller model and the checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ddr2c_regs.vh"
module ddr2_command_init_mode_logic_tb;
	localparam int K_ACT = 0, K_RD = 1, K_WR = 2, K_PRE = 3, K_REF = 4, K_MODE = 5, K_ERR = 6;
	localparam int K_NONE = 7;
	logic clk_sys_in, resetn_in, wdata_ready_in, stall, saw_full;
	wire logic ck_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in;
	wire logic lower_byte_mask_in, upper_byte_mask_in, wdata_valid_out, wdata_accept_out;
	wire logic cmd_activate_out, cmd_read_out, cmd_write_out, cmd_precharge_out;
	wire logic cmd_refresh_out, cmd_mode_out, cmd_error_out, cmd_auto_pre_out;
	wire logic cmd_all_banks_out, mode_valid_out, burst_eight_out, burst_interleave_out;
	wire logic [2:0] ba_in, cmd_bank_out, power_state_out, cas_latency_out, cal_op_out;
	wire logic [13:0] addr_in, cmd_row_out, main_operating_mode, extended_operating_mode;
	wire logic [15:0] dq_in;
	wire logic [`DDR2C_WW-1:0] wdata_out;
	wire logic [9:0] cmd_col_out;
	wire logic [1:0] cmd_mode_sel_out;
	wire logic [7:0] bank_open_out;
	wire logic [6:0] pulses;
	int fails = 0, compares = 0;
	int exp_c[8] = '{default: 0};
	int got_c[8] = '{default: 0};
	logic [`DDR2C_WW-1:0] exp_q[$];
	logic [2:0] cal_c[4] = '{3'h7, 3'h1, 3'h2, 3'h4};
	logic [2:0] dsel_c[4] = '{`DDR2C_C_ACT, `DDR2C_C_RD, `DDR2C_C_WR, `DDR2C_C_REF};

	ddr2c_cmd dut_u (.clk_sys_in, .resetn_in, .ck_in, .cke_in, .cs_n_in, .ras_n_in, .cas_n_in,
		.we_n_in, .ba_in, .addr_in, .lower_byte_mask_in, .upper_byte_mask_in, .dq_in,
		.wdata_ready_in, .wdata_valid_out, .wdata_out, .wdata_accept_out, .cmd_activate_out,
		.cmd_read_out, .cmd_write_out, .cmd_precharge_out, .cmd_refresh_out, .cmd_mode_out,
		.cmd_error_out, .cmd_bank_out, .cmd_row_out, .cmd_col_out, .cmd_auto_pre_out,
		.cmd_all_banks_out, .cmd_mode_sel_out, .bank_open_out, .power_state_out, .mode_valid_out,
		.main_operating_mode, .extended_operating_mode, .burst_eight_out, .burst_interleave_out,
		.cas_latency_out, .cal_op_out);
	ddr2c_ctl_model ctl_u (.clk_sys_in, .ck_out(ck_in), .cke_out(cke_in), .cs_n_out(cs_n_in),
		.ras_n_out(ras_n_in), .cas_n_out(cas_n_in), .we_n_out(we_n_in), .ba_out(ba_in),
		.addr_out(addr_in), .lower_byte_mask_out(lower_byte_mask_in),
		.upper_byte_mask_out(upper_byte_mask_in), .dq_out(dq_in));

	assign pulses = {cmd_error_out, cmd_mode_out, cmd_refresh_out, cmd_precharge_out,
		cmd_write_out, cmd_read_out, cmd_activate_out};
	// 4 ns system clock
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// pulse counts, full flag and drain-side compare against the queue
	always @(posedge clk_sys_in) begin
		for (int j = 0; j < 7; j++) if (pulses[j] === 1'b1) got_c[j]++;
		if (!resetn_in) saw_full <= 1'b0;
		else if (wdata_accept_out === 1'b0) saw_full <= 1'b1;
		if (wdata_valid_out === 1'b1 && wdata_ready_in) check(wdata_out, exp_q.pop_front());
	end
	// drain side stalls at random, or fully while a fill is wanted
	always @(negedge clk_sys_in) wdata_ready_in <= stall ? 1'b0 : 1'($urandom);

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	// one command, then every pulse count compared with the bench's expected count
	task automatic op(input logic k, input logic cs, input logic [2:0] c, input logic [2:0] b,
		input logic [13:0] a, input int kind);
		ctl_u.issue(k, cs, c, b, a);
		exp_c[kind]++;
		repeat (3) @(negedge clk_sys_in);
		for (int j = 0; j < 7; j++) check(got_c[j], exp_c[j]);
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// hang guard: the run needs about 220 us
	initial begin
		#300000;
		fails++;
		tally_and_finish();
	end
	initial begin
		logic [13:0] mv, row;
		logic [9:0] col;
		logic [2:0] b;
		logic [17:0] beats[8];
		logic ap;
		int n, lm, ix, kept;
		void'($urandom(7));
		{resetn_in, stall} = 2'h0;
		repeat (20) @(negedge clk_sys_in);
		resetn_in = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		check(power_state_out, 3'h1);
		check({mode_valid_out, wdata_accept_out}, 2'h1);
		repeat (2500) @(posedge ck_in);
		op(1'h1, 1'h0, `DDR2C_C_NOP, 3'h0, 14'h0000, K_NONE);
		repeat (5) @(posedge ck_in);
		op(1'h1, 1'h0, `DDR2C_C_PRE, 3'h0, 14'h0400, K_PRE);
		check(cmd_all_banks_out, 1'h1);
		op(1'h1, 1'h0, `DDR2C_C_MRS, 3'h2, 14'h0000, K_MODE);
		check(cmd_mode_sel_out, 2'h2);
		op(1'h1, 1'h0, `DDR2C_C_MRS, 3'h3, 14'h0000, K_MODE);
		check(cmd_mode_sel_out, 2'h3);
		op(1'h1, 1'h0, `DDR2C_C_MRS, 3'h1, 14'h0000, K_MODE);
		check(extended_operating_mode, 14'h0000);
		op(1'h1, 1'h0, `DDR2C_C_MRS, 3'h0, 14'h0100, K_MODE);
		check({mode_valid_out, main_operating_mode}, 15'h4100);
		op(1'h1, 1'h0, `DDR2C_C_PRE, 3'h0, 14'h0400, K_PRE);
		for (int j = 0; j < 2; j++) op(1'h1, 1'h0, `DDR2C_C_REF, 3'h0, 14'h0000, K_REF);
		op(1'h1, 1'h0, `DDR2C_C_MRS, 3'h0, 14'h0432, K_MODE);
		check(main_operating_mode, 14'h0432);
		repeat (200) @(posedge ck_in);
		foreach (cal_c[j]) begin
			op(1'h1, 1'h0, `DDR2C_C_MRS, 3'h1, {4'h0, cal_c[j], 7'h00}, K_MODE);
			check(cal_op_out, cal_c[j]);
			op(1'h1, 1'h0, `DDR2C_C_MRS, 3'h1, 14'h0000, K_MODE);
			check(cal_op_out, 3'h0);
		end
		foreach (dsel_c[j]) op(1'h1, 1'h1, dsel_c[j], 3'h0, 14'h0000, K_NONE);
		op(1'h1, 1'h0, `DDR2C_C_RD, 3'h5, 14'h0000, K_ERR);
		// both lengths in both orders; the last pass fills the buffer under stall
		for (int m = 0; m < 4; m++) begin
			n = m[0] ? 8 : 4;
			lm = n - 1;
			mv = {5'h02, 2'h0, 3'h3, m[1], m[0] ? `DDR2C_BL_EIGHT : `DDR2C_BL_FOUR};
			op(1'h1, 1'h0, `DDR2C_C_PRE, 3'h0, 14'h0400, K_PRE);
			op(1'h1, 1'h0, `DDR2C_C_MRS, 3'h0, mv, K_MODE);
			check(main_operating_mode, mv);
			check({burst_eight_out, burst_interleave_out}, {m[0], m[1]});
			check(cas_latency_out, 3'h3);
			b = 3'($urandom);
			row = 14'($urandom);
			col = 10'($urandom);
			ap = 1'($urandom);
			op(1'h1, 1'h0, `DDR2C_C_ACT, b, row, K_ACT);
			check({cmd_bank_out, cmd_row_out, bank_open_out[b]}, {b, row, 1'h1});
			stall = (m == 3);
			kept = 0;
			for (int i = 0; i < 8; i++) begin
				beats[i] = {stall ? 2'($urandom % 3) : 2'($urandom), 16'($urandom)};
				ix = m[1] ? ((col & lm) ^ i) : (((col & lm) + i) & lm);
				if (i < n && beats[i][17:16] != 2'h3 && !(stall && kept == 2)) begin
					exp_q.push_back({b, 10'((col & ~lm) | ix), ~beats[i][17:16], beats[i][15:0]});
					kept++;
				end
			end
			op(1'h1, 1'h0, `DDR2C_C_WR, b, {3'h0, ap, col}, K_WR);
			check({cmd_col_out, cmd_auto_pre_out}, {col, ap});
			ctl_u.burst(2, n, beats);
			repeat (10) @(negedge clk_sys_in);
			check(bank_open_out[b], !ap);
			stall = 1'b0;
			repeat (40) @(negedge clk_sys_in);
			check(exp_q.size(), 0);
		end
		check(saw_full, 1'h1); // stalled fill reached the refusal
		op(1'h1, 1'h0, `DDR2C_C_ACT, 3'h6, 14'h1234, K_ACT);
		op(1'h1, 1'h0, `DDR2C_C_RD, 3'h6, 14'h0400, K_RD);
		check({cmd_auto_pre_out, bank_open_out[6]}, 2'h2);
		op(1'h0, 1'h0, `DDR2C_C_NOP, 3'h0, 14'h0000, K_NONE);
		check(power_state_out, 3'h2);
		op(1'h1, 1'h1, `DDR2C_C_NOP, 3'h0, 14'h0000, K_NONE);
		check(power_state_out, 3'h1);
		op(1'h0, 1'h0, `DDR2C_C_REF, 3'h0, 14'h0000, K_NONE);
		check(power_state_out, 3'h4);
		op(1'h1, 1'h1, `DDR2C_C_NOP, 3'h0, 14'h0000, K_NONE);
		check(power_state_out, 3'h1);
		tally_and_finish();
	end
endmodule // ddr2_command_init_mode_logic_tb

bind ddr2c_cmd ddr2c_cmd_properties chk_u (.clk_sys_in, .resetn_in, .wdata_valid_out,
	.wdata_accept_out, .cmd_activate_out, .cmd_read_out, .cmd_write_out, .cmd_precharge_out,
	.cmd_mode_out, .cmd_error_out, .cmd_bank_out, .cmd_all_banks_out, .cmd_mode_sel_out,
	.bank_open_out, .power_state_out, .mode_valid_out, .main_operating_mode,
	.extended_operating_mode, .burst_eight_out, .burst_interleave_out, .cas_latency_out,
	.cal_op_out);
`default_nettype wire
